// ---- tpr_pkg.sv ----
/*
  Shared constants and types of the timer pin routing block.
  Assumes an 8-bit register port and one 20 MHz system clock.
*/
package tpr_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int TIMERS = 4;
  localparam int PRESCALE_W = 6;
  // register offsets
  localparam logic [5:0] OFF_PIN_A = 6'h00;
  localparam logic [5:0] OFF_PIN_B = 6'h01;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h02;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h03;
  // timer k sits at block k+1 of eight bytes
  localparam logic [2:0] SLOT_CTRL0 = 3'h0;
  localparam logic [2:0] SLOT_CTRL1 = 3'h1;
  localparam logic [2:0] SLOT_CMPA_LO = 3'h2;
  localparam logic [2:0] SLOT_CMPA_HI = 3'h3;
  localparam logic [2:0] SLOT_CMPP = 3'h4;
  // field positions
  localparam int LOW_INV_BIT = 7;
  localparam int HIGH_INV_BIT = 6;
  localparam int PAIR_SEL_LSB = 4;
  localparam int PAUSE_BIT = 7;
  localparam int CLKSEL_LSB = 4;
  localparam int ON_BIT = 3;
  localparam int MODE_LSB = 6;
  localparam int IO_LSB = 4;
  localparam int INIT_LEVEL_BIT = 3;
  localparam int CCLR_BIT = 0;
  // values after reset
  localparam logic [7:0] PIN_CTRL_RESET = 8'hC0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // counter widths
  localparam int STD_WIDTH = 16;
  localparam int PER_WIDTH = 10;
  typedef enum logic [2:0] {
    CLK_SYS_DIV4 = 3'b000, CLK_SYS = 3'b001, CLK_HIGH_DIV16 = 3'b010,
    CLK_HIGH_DIV64 = 3'b011, CLK_TBC_A = 3'b100, CLK_TBC_B = 3'b101,
    CLK_PIN_RISE = 3'b110, CLK_PIN_FALL = 3'b111
  } tpr_clk_sel_e;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00, MODE_CAPTURE = 2'b01, MODE_PWM = 2'b10, MODE_TIMER = 2'b11
  } tpr_mode_e;
  typedef enum logic [1:0] {
    IO_KEEP = 2'b00, IO_LOW = 2'b01, IO_HIGH = 2'b10, IO_TOGGLE = 2'b11
  } tpr_io_e;
  typedef enum logic [1:0] {
    PAIR_GPIO = 2'b00, PAIR_HIGH = 2'b01, PAIR_LOW = 2'b10, PAIR_BOTH = 2'b11
  } tpr_pair_sel_e;
endpackage

// ---- tpr_timer_if.sv ----
/*
  Carrier between the routing top and one timer core.
  Assumes the top drives setup and tick, the core answers with matches and level.
*/
`timescale 1ns/100ps
interface tpr_timer_if;
  import tpr_pkg::*;
  logic tick;
  logic on;
  logic pause;
  logic initLevel;
  logic clearOnA;
  tpr_mode_e mode;
  tpr_io_e io;
  logic [15:0] cmpA;
  logic [7:0] cmpP;
  logic matchA;
  logic matchP;
  logic level;
  modport ctl (output tick, on, pause, initLevel, clearOnA, mode, io, cmpA, cmpP,
    input matchA, matchP, level);
  modport tmr (input tick, on, pause, initLevel, clearOnA, mode, io, cmpA, cmpP,
    output matchA, matchP, level);
endinterface

// ---- tpr_timer.sv ----
/*
  One timer core: up counter cleared on a match of A or P, comparators A and P, output level.
  Assumes tick is a one-cycle count enable on the system clock.
*/
`timescale 1ns/100ps
module tpr_timer
  import tpr_pkg::*;
#(
  parameter int W = STD_WIDTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  tpr_timer_if.tmr tif
);
  if (W < 8 || W > 16) begin : g_bad_width
    $error("tpr_timer: counter width must be 8 to 16");
  end
  logic [W-1:0] count;
  logic onSeen;
  logic level;
  logic [W-1:0] next_count;
  logic next_level;
  // start clears the counter, compares run only on a live tick
  wire start = tif.on & ~onSeen;
  wire run = tif.tick & tif.on & ~tif.pause;
  wire hitA = run & (count == tif.cmpA[W-1:0]);
  wire hitP = run & (count[W-1 -: 8] == tif.cmpP);
  wire clearNow = tif.clearOnA ? hitA : hitP;
  wire compareMode = (tif.mode == MODE_COMPARE);
  assign tif.matchA = hitA;
  assign tif.matchP = hitP;
  assign tif.level = level;
  // next counter value and output level
  always_comb begin
    next_count = count;
    next_level = level;
    if (start) begin
      next_count = '0;
    end else if (clearNow) begin
      next_count = '0;
    end else if (run) begin
      next_count = count + {{(W-1){1'b0}}, 1'b1};
    end
    if (start && compareMode) begin
      next_level = tif.initLevel;
    end else if (hitA && compareMode) begin
      case (tif.io)
        IO_LOW: next_level = 1'b0;
        IO_HIGH: next_level = 1'b1;
        IO_TOGGLE: next_level = ~level;
        default: next_level = level;
      endcase
    end
  end
  // state registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      onSeen <= 1'b0;
      level <= 1'b0;
    end else begin
      count <= next_count;
      onSeen <= tif.on;
      level <= next_level;
    end
  end
endmodule

// ---- tpr_deadtime.sv ----
/*
  Dead-time inserter for one complementary pair.
  Assumes drive is a registered level; both sides stay off for DEAD_CYCLES after a change.
*/
`timescale 1ns/100ps
module tpr_deadtime #(
  parameter int DEAD_CYCLES = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic drive,
  output logic highSide,
  output logic lowSide
);
  if (DEAD_CYCLES < 1 || DEAD_CYCLES > 255) begin : g_bad_dead
    $error("tpr_deadtime: dead time must be 1 to 255 cycles");
  end
  localparam logic [7:0] DEAD_LOAD = 8'(DEAD_CYCLES);
  logic [7:0] gap;
  logic drivePrev;
  wire changed = drive ^ drivePrev;
  wire quiet = enable & (changed | (gap != 8'h00));
  // both sides off while the gap counter runs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gap <= 8'h00;
      drivePrev <= 1'b0;
      highSide <= 1'b0;
      lowSide <= 1'b1;
    end else begin
      drivePrev <= drive;
      gap <= (enable & changed) ? DEAD_LOAD - 8'h01 : (gap != 8'h00 ? gap - 8'h01 : 8'h00);
      highSide <= drive & ~quiet;
      lowSide <= ~drive & ~quiet;
    end
  end
endmodule

// ---- tpr_top.sv ----
/*
  Timer pin routing top: four timers, clock selection, pin enables,
  complementary pairs with dead time, interrupt status and mask.
  Assumes a plain register port with read data one cycle after the strobe,
  and all pin inputs synchronous to clock.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module tpr_top
  import tpr_pkg::*;
#(
  parameter int DEAD_CYCLES = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [5:0] busAddress,
  input wire logic [7:0] busWriteData,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [7:0] busReadData,
  input wire logic timeBaseTick,
  input wire logic [3:0] externalTimerClockIn,
  input wire logic [7:0] portDataInvert,
  output logic [3:0] externalClockConnected,
  output logic [7:0] timerPinEnable,
  output logic [7:0] timerOutputPin,
  output logic pair0HighOutput,
  output logic pair0LowOutput,
  output logic pair0HighEnable,
  output logic pair0LowEnable,
  output logic pair1HighOutput,
  output logic pair1LowOutput,
  output logic pair1HighEnable,
  output logic pair1LowEnable,
  output logic irq
);
  // registers
  logic [7:0] pinCtrlA;
  logic [7:0] pinCtrlB;
  logic [7:0] irqStatus;
  logic [7:0] irqMask;
  logic [7:0] ctrl0 [TIMERS];
  logic [7:0] ctrl1 [TIMERS];
  logic [7:0] cmpALo [TIMERS];
  logic [7:0] cmpAHi [TIMERS];
  logic [7:0] cmpP [TIMERS];
  logic [PRESCALE_W-1:0] prescale;
  logic [3:0] extPrev;
  logic [7:0] next_readData;
  logic [7:0] matchEvents;
  logic [3:0] tickVec;
  logic [3:0] levelVec;

  // address decode
  wire [2:0] blockNum = busAddress[5:3];
  wire [2:0] slot = busAddress[2:0];
  wire [2:0] blockLess = blockNum - 3'h1;
  wire [1:0] timerIdx = blockLess[1:0];
  wire isTimer = (blockNum >= 3'h1) && (blockNum <= 3'h4) && (slot <= SLOT_CMPP);
  wire hitPinA = (busAddress == OFF_PIN_A);
  wire hitPinB = (busAddress == OFF_PIN_B);
  wire hitStatus = (busAddress == OFF_IRQ_STATUS);
  wire hitMask = (busAddress == OFF_IRQ_MASK);
  wire statusReadClear = busRead & hitStatus;

  // clock enables: system clock and internal high clock share one rate here
  wire div4Tick = (prescale[1:0] == 2'h3);
  wire div16Tick = (prescale[3:0] == 4'hF);
  wire div64Tick = (prescale == 6'h3F);
  wire [3:0] extRise = externalTimerClockIn & ~extPrev;
  wire [3:0] extFall = ~externalTimerClockIn & extPrev;

  // free-running prescaler and pin edge history
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prescale <= '0;
      extPrev <= 4'h0;
    end else begin
      prescale <= prescale + 6'h01;
      extPrev <= externalTimerClockIn;
    end
  end

  // per-timer clock select, carrier wiring and timer cores
  for (genvar k = 0; k < TIMERS; k++) begin : g_tmr
    tpr_timer_if tif ();
    tpr_clk_sel_e sel;
    logic tickSel;
    assign sel = tpr_clk_sel_e'(ctrl0[k][CLKSEL_LSB +: 3]);
    assign externalClockConnected[k] = sel[2] & sel[1];
    always_comb begin
      case (sel)
        CLK_SYS_DIV4: tickSel = div4Tick;
        CLK_SYS: tickSel = 1'b1;
        CLK_HIGH_DIV16: tickSel = div16Tick;
        CLK_HIGH_DIV64: tickSel = div64Tick;
        CLK_TBC_A: tickSel = timeBaseTick;
        CLK_TBC_B: tickSel = timeBaseTick;
        CLK_PIN_RISE: tickSel = extRise[k];
        CLK_PIN_FALL: tickSel = extFall[k];
        default: tickSel = 1'b0;
      endcase
    end
    assign tickVec[k] = tickSel;
    assign tif.tick = tickSel;
    assign tif.on = ctrl0[k][ON_BIT];
    assign tif.pause = ctrl0[k][PAUSE_BIT];
    assign tif.mode = tpr_mode_e'(ctrl1[k][MODE_LSB +: 2]);
    assign tif.io = tpr_io_e'(ctrl1[k][IO_LSB +: 2]);
    assign tif.initLevel = ctrl1[k][INIT_LEVEL_BIT];
    assign tif.clearOnA = ctrl1[k][CCLR_BIT];
    assign tif.cmpA = {cmpAHi[k], cmpALo[k]};
    assign tif.cmpP = cmpP[k];
    assign matchEvents[2*k] = tif.matchA;
    assign matchEvents[2*k+1] = tif.matchP;
    assign levelVec[k] = tif.level;
    tpr_timer #(.W(k == 0 ? STD_WIDTH : PER_WIDTH)) u_timer (
      .clock(clock),
      .sys_rst(sys_rst),
      .tif(tif)
    );
  end

  // register writes; hardware set wins over read clear of status
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pinCtrlA <= PIN_CTRL_RESET;
      pinCtrlB <= PIN_CTRL_RESET;
      irqStatus <= REG_RESET;
      irqMask <= REG_RESET;
      for (int i = 0; i < TIMERS; i++) begin
        ctrl0[i] <= REG_RESET;
        ctrl1[i] <= REG_RESET;
        cmpALo[i] <= REG_RESET;
        cmpAHi[i] <= REG_RESET;
        cmpP[i] <= REG_RESET;
      end
    end else begin
      irqStatus <= (irqStatus & ~{8{statusReadClear}}) | matchEvents;
      if (busWrite && hitPinA) begin
        pinCtrlA <= busWriteData;
      end
      if (busWrite && hitPinB) begin
        pinCtrlB <= busWriteData;
      end
      if (busWrite && hitMask) begin
        irqMask <= busWriteData;
      end
      for (int i = 0; i < TIMERS; i++) begin
        if (busWrite && isTimer && timerIdx == 2'(i)) begin
          case (slot)
            SLOT_CTRL0: ctrl0[i] <= busWriteData & 8'hF8;
            SLOT_CTRL1: ctrl1[i] <= busWriteData;
            SLOT_CMPA_LO: cmpALo[i] <= busWriteData;
            SLOT_CMPA_HI: cmpAHi[i] <= busWriteData;
            SLOT_CMPP: cmpP[i] <= busWriteData;
            default: ;
          endcase
        end
      end
    end
  end

  // read data select; unmapped addresses read zero
  always_comb begin
    next_readData = 8'h00;
    if (busRead) begin
      if (hitPinA) begin
        next_readData = pinCtrlA;
      end else if (hitPinB) begin
        next_readData = pinCtrlB;
      end else if (hitStatus) begin
        next_readData = irqStatus;
      end else if (hitMask) begin
        next_readData = irqMask;
      end else if (isTimer) begin
        case (slot)
          SLOT_CTRL0: next_readData = ctrl0[timerIdx];
          SLOT_CTRL1: next_readData = ctrl1[timerIdx];
          SLOT_CMPA_LO: next_readData = cmpALo[timerIdx];
          SLOT_CMPA_HI: next_readData = cmpAHi[timerIdx];
          SLOT_CMPP: next_readData = cmpP[timerIdx];
          default: next_readData = 8'h00;
        endcase
      end
    end
  end

  // pair field decode
  tpr_pair_sel_e pair0Sel;
  tpr_pair_sel_e pair1Sel;
  assign pair0Sel = tpr_pair_sel_e'(pinCtrlA[PAIR_SEL_LSB +: 2]);
  assign pair1Sel = tpr_pair_sel_e'(pinCtrlB[PAIR_SEL_LSB +: 2]);
  wire pair0DeadOn = (pair0Sel == PAIR_BOTH);
  wire pair1DeadOn = (pair1Sel == PAIR_BOTH);
  logic dt0High;
  logic dt0Low;
  logic dt1High;
  logic dt1Low;

  // dead-time inserters, pair 0 from timer 0, pair 1 from timer 2
  tpr_deadtime #(.DEAD_CYCLES(DEAD_CYCLES)) u_dead0 (
    .clock(clock),
    .sys_rst(sys_rst),
    .enable(pair0DeadOn),
    .drive(levelVec[0]),
    .highSide(dt0High),
    .lowSide(dt0Low)
  );
  tpr_deadtime #(.DEAD_CYCLES(DEAD_CYCLES)) u_dead1 (
    .clock(clock),
    .sys_rst(sys_rst),
    .enable(pair1DeadOn),
    .drive(levelVec[2]),
    .highSide(dt1High),
    .lowSide(dt1Low)
  );

  // pin values: both pins of each timer may be inverted by port data
  wire [7:0] next_pins = {
    levelVec[3] ^ portDataInvert[7], levelVec[3] ^ portDataInvert[6],
    levelVec[2] ^ portDataInvert[5], levelVec[2] ^ portDataInvert[4],
    levelVec[1] ^ portDataInvert[3], levelVec[1] ^ portDataInvert[2],
    levelVec[0] ^ portDataInvert[1], levelVec[0] ^ portDataInvert[0]};

  // output registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busReadData <= 8'h00;
      irq <= 1'b0;
      timerOutputPin <= 8'h00;
      timerPinEnable <= 8'h00;
      pair0HighOutput <= 1'b0;
      pair0LowOutput <= 1'b0;
      pair1HighOutput <= 1'b0;
      pair1LowOutput <= 1'b0;
      pair0HighEnable <= 1'b0;
      pair0LowEnable <= 1'b0;
      pair1HighEnable <= 1'b0;
      pair1LowEnable <= 1'b0;
    end else begin
      busReadData <= next_readData;
      irq <= |(irqStatus & irqMask);
      timerOutputPin <= next_pins;
      timerPinEnable <= {pinCtrlB[3:0], pinCtrlA[3:0]};
      pair0HighOutput <= dt0High ^ pinCtrlA[HIGH_INV_BIT];
      pair0LowOutput <= dt0Low ^ pinCtrlA[LOW_INV_BIT];
      pair1HighOutput <= dt1High ^ pinCtrlB[HIGH_INV_BIT];
      pair1LowOutput <= dt1Low ^ pinCtrlB[LOW_INV_BIT];
      pair0HighEnable <= pair0Sel[0];
      pair0LowEnable <= pair0Sel[1];
      pair1HighEnable <= pair1Sel[0];
      pair1LowEnable <= pair1Sel[1];
    end
  end

  // checks beside the logic
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  irq_follows_match_a: assert property (
    (matchEvents[0] && irqMask[0]) |-> ##2 irq)
    else $error("unmasked match did not raise irq");
  status_sticky_a: assert property (
    (irqStatus[1] && !statusReadClear) |=> irqStatus[1])
    else $error("status bit dropped without a read");
  read_clear_a: assert property (
    (statusReadClear && matchEvents == 8'h00) |=> irqStatus == 8'h00)
    else $error("status read did not clear");
  dead_gap_a: assert property (
    (pair0DeadOn && $changed(levelVec[0])) |=> (!dt0High && !dt0Low))
    else $error("no dead gap on pair 0");
  no_dead_pass_a: assert property (
    !pair1DeadOn |=> (dt1High == $past(levelVec[2])) && (dt1Low != $past(levelVec[2])))
    else $error("pair 1 not passed through");
  pin_enable_a: assert property (
    (busWrite && hitPinA) |-> ##2 timerPinEnable[3:0] == $past(busWriteData[3:0], 2))
    else $error("pin enables of timers 0 and 1 wrong");
  pin_enable_b_a: assert property (
    (busWrite && hitPinB) |-> ##2 timerPinEnable[7:4] == $past(busWriteData[3:0], 2))
    else $error("pin enables of timers 2 and 3 wrong");
  ext_gate_a: assert property (
    (!externalClockConnected[1] && extRise[1] && !div4Tick && !div16Tick && !timeBaseTick
      && ctrl0[1][CLKSEL_LSB +: 3] != 3'b001) |-> !tickVec[1])
    else $error("external pin ticked an unselected timer");
  ext_edge_a: assert property (
    (ctrl0[3][CLKSEL_LSB +: 3] == 3'b111) |-> (tickVec[3] == (extPrev[3] && !externalTimerClockIn[3])))
    else $error("falling edge select miscounts");
  low_invert_a: assert property (
    ##1 (pair0LowOutput == $past(dt0Low ^ pinCtrlA[LOW_INV_BIT])))
    else $error("pair 0 low inversion wrong");
  read_data_a: assert property (
    (busRead && hitPinA) |=> busReadData == $past(pinCtrlA))
    else $error("pin control read back wrong");
  irq_from_p_a: assert property (
    (matchEvents[3] && irqMask[3]) |-> ##2 irq)
    else $error("unmasked match P did not raise irq");
  pair_high_only_a: assert property (
    (busWrite && hitPinA && busWriteData[5:4] == 2'b01) |-> ##2 (pair0HighEnable && !pair0LowEnable))
    else $error("pair 0 high-only field wrong");
  pair_low_only_a: assert property (
    (busWrite && hitPinB && busWriteData[5:4] == 2'b10) |-> ##2 (pair1LowEnable && !pair1HighEnable))
    else $error("pair 1 low-only field wrong");
  dead_gap_b_a: assert property (
    (pair1DeadOn && $changed(levelVec[2])) |=> (!dt1High && !dt1Low))
    else $error("no dead gap on pair 1");
  // pair 1 outputs: dead-time stage lags the level by one cycle, the pin register by one more
  high_invert_b_a: assert property (
    !pair1DeadOn |=> ##1 (pair1HighOutput == ($past(levelVec[2], 2) ^ $past(pinCtrlB[HIGH_INV_BIT]))))
    else $error("pair 1 high inversion wrong");
  low_invert_b_a: assert property (
    !pair1DeadOn |=> ##1 (pair1LowOutput == (!$past(levelVec[2], 2) ^ $past(pinCtrlB[LOW_INV_BIT]))))
    else $error("pair 1 low inversion wrong");
  mode_hold_a: assert property (
    (ctrl1[2][MODE_LSB +: 2] != 2'b00) |=> $stable(levelVec[2]))
    else $error("timer 2 pin moved outside compare mode");

  irq_seen_c: cover property ($rose(irq));
  status_clear_c: cover property (statusReadClear && irqStatus != 8'h00);
  pair_both_c: cover property (pair0DeadOn ##1 $changed(levelVec[0]));
  ext_tick_c: cover property (externalClockConnected[0] && tickVec[0]);
  toggle_c: cover property ($changed(levelVec[1]));
endmodule

// ---- tpr_pin_partner.sv ----
/*
  External pin model: timer clock inputs and the time-base pulse.
  Assumes the bench calls pulse() from its own thread; clock lines idle low like a pulled-down pin.
*/
`timescale 1ns/100ps
module tpr_pin_partner (
  input wire logic clock,
  input wire logic sys_rst,
  output logic [3:0] externalTimerClockIn,
  output logic timeBaseTick
);
  logic [2:0] tbCount;
  initial externalTimerClockIn = 4'h0;
  // time-base pulse, one cycle in eight
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tbCount <= 3'h0;
    end else begin
      tbCount <= tbCount + 3'h1;
    end
  end
  assign timeBaseTick = (tbCount == 3'h7);
  // n slow pulses on clock pin k, two cycles high and two low, so every edge is seen
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clock);
      externalTimerClockIn[k] <= 1'b1;
      repeat (2) @(posedge clock);
      externalTimerClockIn[k] <= 1'b0;
      @(posedge clock);
    end
  endtask
endmodule

// ---- timer_pin_routing_test.sv ----
/*
  Self-checking bench of the timer pin routing top: register port, pin routing, timers, interrupt.
  Assumes the pin partner model drives the clock pins and the time-base pulse.
*/
`timescale 1ns/100ps
`define CHK(name, exp, got) begin nCompared++; if ((got) !== (exp)) begin numErrors++; \
  $display("MISMATCH %s expected %h seen %h", name, exp, got); end end
module timer_pin_routing_test;
  import tpr_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] busAddress = 6'h00;
  logic [7:0] busWriteData = 8'h00;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [7:0] portDataInvert = 8'hAA;
  logic [7:0] busReadData, timerPinEnable, timerOutputPin;
  logic [3:0] externalTimerClockIn, externalClockConnected;
  logic timeBaseTick, irq, seen, lvl;
  logic pair0HighOutput, pair0LowOutput, pair0HighEnable, pair0LowEnable;
  logic pair1HighOutput, pair1LowOutput, pair1HighEnable, pair1LowEnable;
  logic [5:0] base;
  int numErrors = 0;
  int nCompared = 0;
  always #25 clock = ~clock;
  tpr_top #(.DEAD_CYCLES(2)) i_dut (.clock(clock), .sys_rst(sys_rst), .busAddress(busAddress),
    .busWriteData(busWriteData), .busWrite(busWrite), .busRead(busRead), .busReadData(busReadData),
    .timeBaseTick(timeBaseTick), .externalTimerClockIn(externalTimerClockIn),
    .portDataInvert(portDataInvert), .externalClockConnected(externalClockConnected),
    .timerPinEnable(timerPinEnable), .timerOutputPin(timerOutputPin),
    .pair0HighOutput(pair0HighOutput), .pair0LowOutput(pair0LowOutput),
    .pair0HighEnable(pair0HighEnable), .pair0LowEnable(pair0LowEnable),
    .pair1HighOutput(pair1HighOutput), .pair1LowOutput(pair1LowOutput),
    .pair1HighEnable(pair1HighEnable), .pair1LowEnable(pair1LowEnable), .irq(irq));
  tpr_pin_partner i_pins (.clock(clock), .sys_rst(sys_rst), .externalTimerClockIn(externalTimerClockIn),
    .timeBaseTick(timeBaseTick));
  // wait n edges, then let that edge's updates land
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    busWrite <= 1'b1;
    busAddress <= a;
    busWriteData <= d;
    @(posedge clock);
    busWrite <= 1'b0;
  endtask
  // one-cycle read strobe, data checked in the following cycle only
  task automatic rchk(input string name, input logic [5:0] a, input logic [7:0] want);
    @(posedge clock);
    busRead <= 1'b1;
    busAddress <= a;
    @(posedge clock);
    busRead <= 1'b0;
    #1;
    `CHK(name, want, busReadData)
  endtask
  // counts, verdict and end of run
  task automatic end_sim();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog well beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    numErrors++;
    end_sim();
  end
  // main sequence; timers stay in compare mode except timer 2 in timer mode at the end, never capture, so several pin enables are legal
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    cyc(2);
    `CHK("pair0Low", 1'b0, pair0LowOutput)
    `CHK("pair0High", 1'b1, pair0HighOutput)
    `CHK("pair1Low", 1'b0, pair1LowOutput)
    `CHK("pair1High", 1'b1, pair1HighOutput)
    rchk("pinA", OFF_PIN_A, 8'hC0);
    rchk("pinB", OFF_PIN_B, 8'hC0);
    rchk("status", OFF_IRQ_STATUS, 8'h00);
    rchk("unmapped", 6'h3F, 8'h00);
    `CHK("pinEnableReset", 8'h00, timerPinEnable)
    $display("test reset done");
    // every pair field code on both pin registers
    for (int f = 0; f < 4; f++) begin
      wr(OFF_PIN_A, {2'b11, 2'(f), 4'hF});
      wr(OFF_PIN_B, {2'b00, 2'(f), 4'hF});
      cyc(2);
      `CHK("pinEnable", 8'hFF, timerPinEnable)
      `CHK("pair0HighEn", f[0], pair0HighEnable)
      `CHK("pair0LowEn", f[1], pair0LowEnable)
      `CHK("pair1HighEn", f[0], pair1HighEnable)
      `CHK("pair1LowEn", f[1], pair1LowEnable)
      rchk("pinBBack", OFF_PIN_B, {2'b00, 2'(f), 4'hF});
    end
    wr(OFF_PIN_A, 8'hC5);
    wr(OFF_PIN_B, 8'h0A);
    cyc(2);
    `CHK("pinEnable", 8'hA5, timerPinEnable)
    $display("test pin fields done");
    // timer 0 toggles every third cycle; both pair outputs alike only during a dead gap
    wr(6'h09, 8'h31);
    wr(6'h0A, 8'h02);
    wr(6'h08, 8'h18);
    for (int f = 1; f < 4; f += 2) begin
      wr(OFF_PIN_A, {2'b11, 2'(f), 4'h0});
      seen = 1'b0;
      repeat (30) begin
        cyc(1);
        seen |= (pair0HighOutput === pair0LowOutput);
      end
      `CHK("deadGap", f == 3, seen)
    end
    wr(6'h08, 8'h10);
    $display("test dead time done");
    // clock select: pin owned only for the two pin codes
    for (int k = 0; k < 4; k++) begin
      base = 6'(8 + 8 * k);
      wr(base, 8'h77);
      cyc(1);
      `CHK("extConnFall", 1'b1, externalClockConnected[k])
      rchk("ctrl0", base, 8'h70);
      wr(base, 8'h60);
      cyc(1);
      `CHK("extConnRise", 4'h1 << k, externalClockConnected)
      wr(base, 8'h10);
      cyc(1);
      `CHK("extConnOff", 4'h0, externalClockConnected)
    end
    $display("test clock select done");
    // compare output high or low, both comparators raise status, mask gates irq
    wr(OFF_IRQ_MASK, 8'h0C);
    rchk("mask", OFF_IRQ_MASK, 8'h0C);
    for (int k = 0; k < 4; k++) begin
      base = 6'(8 + 8 * k);
      lvl = ~k[0];
      wr(base + 6'h1, k[0] ? 8'h19 : 8'h21);
      wr(base + 6'h2, 8'h02);
      wr(base + 6'h3, (k == 0) ? 8'h01 : 8'h00);
      wr(base, 8'h18);
      cyc(300);
      `CHK("pin0", lvl ^ portDataInvert[2 * k], timerOutputPin[2 * k])
      `CHK("pin1", lvl ^ portDataInvert[2 * k + 1], timerOutputPin[2 * k + 1])
      wr(base, 8'h10);
      cyc(3);
      `CHK("irq", k == 1, irq)
      rchk("statusSet", OFF_IRQ_STATUS, 8'h03 << (2 * k));
      rchk("statusClr", OFF_IRQ_STATUS, 8'h00);
      cyc(2);
      `CHK("irqClr", 1'b0, irq)
    end
    $display("test compare done");
    // timer 3 counts rising edges of its clock pin and toggles on the third
    wr(6'h21, 8'h31);
    wr(6'h22, 8'h02);
    wr(6'h20, 8'h68);
    i_pins.pulse(3, 2);
    cyc(4);
    `CHK("edgeCount2", 1'b0, timerOutputPin[6])
    i_pins.pulse(3, 1);
    cyc(4);
    `CHK("edgeCount3", 1'b1, timerOutputPin[6])
    // timer 1 on the time-base clock must ignore its own clock pin
    wr(6'h10, 8'h40);
    i_pins.pulse(1, 1);
    `CHK("extConnPin3", 4'h8, externalClockConnected)
    $display("test external clock done");
    // outside compare mode a match leaves the pin where it was
    wr(6'h19, 8'hF1);
    wr(6'h18, 8'h18);
    cyc(20);
    `CHK("modeHold", 1'b1, timerOutputPin[4])
    $display("test mode hold done");
    end_sim();
  end
endmodule
